//--- rtl/tpgc_top.sv
/*
 * Three-phase gate control logic: APB registers, per-phase gate decode,
 * short detection with blanking, temperature flags and diagnostic pin.
 * Assumes analog comparators, the temperature sensor with its hysteresis
 * and the diagnostic analog mux sit outside and are synchronous to pclk.
 */
// Behaviour
// - each control state is the OR of its pin and its run-register bit.
// - three phases, each with its own states and gate outputs.
// - coast off, both states 0: both gates low, node floats.
// - coast off, only low state: low gate high, high gate low.
// - coast off, only high state: high gate high, low gate low.
// - both states 1: both gates forced low.
// - override low drives every gate output low.
// - high side on and supply-minus-node over threshold: short-to-ground fault.
// - low side on and node-minus-source over threshold: short-to-battery fault.
// - selector 01 divided clock, 10 drain-source threshold, 11 temperature voltage.
// - temperature mode voltage follows junction temperature, 1420 mV, -3.85 mV/C.
// - hot warning set near 135 C, cleared 15 C lower.
// - overtemperature flag set near 170 C, cleared 15 C lower.
// - low pulse on fault clear input clears latched faults.
// - diagnostic pin has four functions, fault flag after power-up.
`timescale 1ns/1ps
module tpgc_top
    import tpgc_pkg::*;
#(
    parameter int PIN_A_DIV = TPGC_PIN_A_DIV,
    parameter int NPHASE = TPGC_NPHASE
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPHASE-1:0] phase_high_pin,
    input wire logic [NPHASE-1:0] phase_low_pin,
    input wire logic freewheel_override_n,
    input wire logic fault_clear_n,
    input wire logic [NPHASE-1:0] stg_cmp,
    input wire logic [NPHASE-1:0] stb_cmp,
    input wire logic temp_warn_cmp,
    input wire logic overtemp_cmp,
    output logic [NPHASE-1:0] high_gate_out,
    output logic [NPHASE-1:0] low_gate_out,
    output logic [TPGC_THRESH_W-1:0] drain_source_threshold,
    output logic [1:0] pin_a_analog_sel,
    output logic pin_a
);

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    localparam int DIV_HALF = PIN_A_DIV / 2;
    localparam int DIV_W = $clog2(DIV_HALF);

    logic [TPGC_RUN_W-1:0] run_r;
    logic [1:0] pin_a_sel_r;
    logic [TPGC_BLANK_W-1:0] blank_r;
    logic [TPGC_THRESH_W-1:0] thresh_r;
    logic [NPHASE-1:0] stg_flag_r;
    logic [NPHASE-1:0] stb_flag_r;
    logic warn_r;
    logic ot_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [NPHASE-1:0] high_gate_r;
    logic [NPHASE-1:0] low_gate_r;
    logic [DIV_W-1:0] div_cnt_r;
    logic div_clk_r;
    logic pin_a_r;
    logic [1:0] pin_a_analog_r;

    wire access = psel & penable;
    wire done = access & pready_r;
    wire sel_run = paddr == TPGC_RUN_OFS;
    wire sel_cfg = paddr == TPGC_CFG_OFS;
    wire sel_status = paddr == TPGC_STATUS_OFS;
    wire sel_thresh = paddr == TPGC_THRESH_OFS;
    wire mapped = sel_run | sel_cfg | sel_status | sel_thresh;
    wire wr_run = done & pwrite & sel_run;
    wire wr_cfg = done & pwrite & sel_cfg;
    wire wr_thresh = done & pwrite & sel_thresh;

    // combined fault flag seen on status and on the diagnostic pin
    wire fault_flag = (|stg_flag_r) | (|stb_flag_r) | ot_r;

    wire [31:0] status_word = {23'h0, fault_flag, ot_r, warn_r, stb_flag_r, stg_flag_r};
    wire [31:0] cfg_word = {16'h0, blank_r, 6'h0, pin_a_sel_r};
    wire [31:0] rd_word = sel_run ? {26'h0, run_r} :
                          sel_cfg ? cfg_word :
                          sel_status ? status_word :
                          sel_thresh ? {27'h0, thresh_r} : 32'h0;

    // ------------------------------------------------------------------
    // per-phase gate decode and short detection
    // ------------------------------------------------------------------
    logic [NPHASE-1:0] high_gate_nxt;
    logic [NPHASE-1:0] low_gate_nxt;
    logic [NPHASE-1:0] stg_evt;
    logic [NPHASE-1:0] stb_evt;

    genvar p;
    generate
        for (p = 0; p < NPHASE; p++)
        begin : g_phase
            tpgc_phase u_phase (
                .phase_high_pin(phase_high_pin[p]),
                .phase_low_pin(phase_low_pin[p]),
                .run_high_bit(run_r[2*p]),
                .run_low_bit(run_r[2*p+1]),
                .freewheel_override_n(freewheel_override_n),
                .high_gate_nxt(high_gate_nxt[p]),
                .low_gate_nxt(low_gate_nxt[p])
            );

            // short-to-ground: high side commanded on
            tpgc_blank u_stg (
                .pclk(pclk),
                .presetn(presetn),
                .gate_on(high_gate_r[p]),
                .short_cmp(stg_cmp[p]),
                .blank_cycles(blank_r),
                .short_evt(stg_evt[p])
            );

            // short-to-battery: low side commanded on
            tpgc_blank u_stb (
                .pclk(pclk),
                .presetn(presetn),
                .gate_on(low_gate_r[p]),
                .short_cmp(stb_cmp[p]),
                .blank_cycles(blank_r),
                .short_evt(stb_evt[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // latched faults: a new event wins over a concurrent clear
    // ------------------------------------------------------------------
    wire clr = ~fault_clear_n;
    wire [NPHASE-1:0] stg_nxt = stg_evt | (stg_flag_r & {NPHASE{~clr}});
    wire [NPHASE-1:0] stb_nxt = stb_evt | (stb_flag_r & {NPHASE{~clr}});

    // ------------------------------------------------------------------
    // diagnostic pin
    // ------------------------------------------------------------------
    // square wave at pclk / PIN_A_DIV: toggles every half period
    wire div_wrap = div_cnt_r == DIV_W'(DIV_HALF - 1);
    wire [DIV_W-1:0] div_cnt_nxt = div_wrap ? '0 : div_cnt_r + DIV_W'(1);
    wire pin_a_is_fault = pin_a_sel_r == TPGC_PIN_A_FAULT;
    wire pin_a_is_clock = pin_a_sel_r == TPGC_PIN_A_CLOCK;
    // analog functions (threshold, temperature) leave the digital drive low
    // and steer the external mux instead
    wire pin_a_nxt = pin_a_is_fault ? fault_flag : (pin_a_is_clock ? div_clk_r : 1'b0);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end
        else
        begin
            // one wait state: pready rises on the second access cycle
            pready_r <= access & ~pready_r;
            pslverr_r <= access & ~pready_r & ~mapped;
            prdata_r <= (access & ~pready_r & ~pwrite) ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_r <= TPGC_RUN_RST;
        end
        else if (wr_run)
        begin
            run_r <= pwdata[TPGC_RUN_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_a_sel_r <= TPGC_PIN_A_RST;
            blank_r <= TPGC_BLANK_RST;
        end
        else if (wr_cfg)
        begin
            pin_a_sel_r <= pwdata[TPGC_CFG_PIN_A_LSB +: 2];
            blank_r <= pwdata[TPGC_CFG_BLANK_LSB +: TPGC_BLANK_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            thresh_r <= TPGC_THRESH_RST;
        end
        else if (wr_thresh)
        begin
            thresh_r <= pwdata[TPGC_THRESH_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            high_gate_r <= '0;
            low_gate_r <= '0;
        end
        else
        begin
            high_gate_r <= high_gate_nxt;
            low_gate_r <= low_gate_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stg_flag_r <= '0;
            stb_flag_r <= '0;
        end
        else
        begin
            stg_flag_r <= stg_nxt;
            stb_flag_r <= stb_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            warn_r <= 1'b0;
            ot_r <= 1'b0;
        end
        else
        begin
            // comparators carry the thermal hysteresis; flags follow them
            warn_r <= temp_warn_cmp;
            ot_r <= overtemp_cmp;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_r <= '0;
            div_clk_r <= 1'b0;
        end
        else
        begin
            div_cnt_r <= div_cnt_nxt;
            div_clk_r <= div_clk_r ^ div_wrap;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_a_r <= 1'b0;
            pin_a_analog_r <= TPGC_PIN_A_RST;
        end
        else
        begin
            pin_a_r <= pin_a_nxt;
            pin_a_analog_r <= pin_a_sel_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign high_gate_out = high_gate_r;
    assign low_gate_out = low_gate_r;
    assign drain_source_threshold = thresh_r;
    assign pin_a_analog_sel = pin_a_analog_r;
    assign pin_a = pin_a_r;

endmodule // tpgc_top

//--- rtl/tpgc_pkg.sv
/*
 * Shared constants for the three-phase gate control logic: register map,
 * field positions, reset values and timing counts.
 * Assumes a 50 MHz pclk and a 32-bit APB register bus.
 */
package tpgc_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int TPGC_CLK_PERIOD_NS = 20;
    localparam int TPGC_BLANK_NS = 3200;
    localparam int TPGC_BLANK_CYC = TPGC_BLANK_NS / TPGC_CLK_PERIOD_NS;
    localparam int TPGC_PIN_A_DIV = 409600;
    localparam int TPGC_NPHASE = 3;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] TPGC_RUN_OFS = 8'h00;
    localparam logic [7:0] TPGC_CFG_OFS = 8'h04;
    localparam logic [7:0] TPGC_STATUS_OFS = 8'h08;
    localparam logic [7:0] TPGC_THRESH_OFS = 8'h0C;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    // run: bit 2p = run_high_bit of phase p, bit 2p+1 = run_low_bit
    localparam int TPGC_RUN_W = 6;
    localparam int TPGC_CFG_PIN_A_LSB = 0;
    localparam int TPGC_CFG_BLANK_LSB = 8;
    localparam int TPGC_BLANK_W = 8;
    localparam int TPGC_THRESH_W = 5;
    localparam int TPGC_ST_STG_LSB = 0;
    localparam int TPGC_ST_STB_LSB = 3;
    localparam int TPGC_ST_WARN = 6;
    localparam int TPGC_ST_OT = 7;
    localparam int TPGC_ST_FAULT = 8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [TPGC_RUN_W-1:0] TPGC_RUN_RST = 6'h00;
    localparam logic [1:0] TPGC_PIN_A_RST = 2'h0;
    localparam logic [TPGC_BLANK_W-1:0] TPGC_BLANK_RST = TPGC_BLANK_W'(TPGC_BLANK_CYC);
    localparam logic [TPGC_THRESH_W-1:0] TPGC_THRESH_RST = 5'h08;

    // diagnostic pin functions
    typedef enum logic [1:0] {
        TPGC_PIN_A_FAULT = 2'h0,
        TPGC_PIN_A_CLOCK = 2'h1,
        TPGC_PIN_A_VDS = 2'h2,
        TPGC_PIN_A_TEMP = 2'h3
    } tpgc_pin_a_t;

endpackage

//--- rtl/tpgc_phase.sv
/*
 * Gate decode for one phase: combines pin and run-register control and
 * maps the result to next-state gate levels.
 * Assumes the caller registers the outputs.
 */
`timescale 1ns/1ps
module tpgc_phase
    import tpgc_pkg::*;
(
    input wire logic phase_high_pin,
    input wire logic phase_low_pin,
    input wire logic run_high_bit,
    input wire logic run_low_bit,
    input wire logic freewheel_override_n,
    output logic high_gate_nxt,
    output logic low_gate_nxt
);

    wire high_control_state = phase_high_pin | run_high_bit;
    wire low_control_state = phase_low_pin | run_low_bit;

    // both-on decodes to off so the half bridge can never shoot through
    assign high_gate_nxt = freewheel_override_n & high_control_state & ~low_control_state;
    assign low_gate_nxt = freewheel_override_n & low_control_state & ~high_control_state;
    // neither state: both gates low, node floats

endmodule // tpgc_phase

//--- rtl/tpgc_blank.sv
/*
 * Short detector for one switch: blanks the comparator after gate turn-on
 * and flags a fault only if it still trips afterwards.
 * Assumes the comparator input is already synchronous to pclk.
 */
`timescale 1ns/1ps
module tpgc_blank
    import tpgc_pkg::*;
#(
    parameter int BLANK_W = TPGC_BLANK_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic gate_on,
    input wire logic short_cmp,
    input wire logic [BLANK_W-1:0] blank_cycles,
    output logic short_evt
);

    logic [BLANK_W-1:0] cnt_r;
    logic gate_d_r;

    wire turn_on = gate_on & ~gate_d_r;
    wire blanked = cnt_r < blank_cycles;
    wire [BLANK_W-1:0] cnt_nxt = turn_on ? '0 : (blanked ? cnt_r + BLANK_W'(1) : cnt_r);

    assign short_evt = gate_on & ~turn_on & ~blanked & short_cmp;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= '0;
            gate_d_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            gate_d_r <= gate_on;
        end
    end

endmodule // tpgc_blank

//--- dv/tpgc_top_asserts.sv
/* Port-level checks on the gate control top.
   Bound to every tpgc_top; blank length is not visible here. */
`timescale 1ns/1ps
module tpgc_top_asserts
#(
    parameter int NPHASE = 3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NPHASE-1:0] phase_high_pin,
    input wire logic [NPHASE-1:0] phase_low_pin,
    input wire logic freewheel_override_n,
    input wire logic fault_clear_n,
    input wire logic [NPHASE-1:0] stg_cmp,
    input wire logic [NPHASE-1:0] stb_cmp,
    input wire logic overtemp_cmp,
    input wire logic [NPHASE-1:0] high_gate_out,
    input wire logic [NPHASE-1:0] low_gate_out,
    input wire logic [1:0] pin_a_analog_sel,
    input wire logic pin_a
);
    // ------------------------------------------------------------
    // sequences and checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    // quiet inputs so that nothing can set a flag while clearing
    sequence s_quiet;
        !fault_clear_n && stg_cmp == '0 && stb_cmp == '0 && !overtemp_cmp
            && pin_a_analog_sel == 2'h0;
    endsequence
    a_ready_after:
        assert property (s_setup ##1 s_access |=> pready) else $error("pready late");
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("pready held");
    a_err_ready:
        assert property (pslverr |-> pready) else $error("pslverr alone");
    a_coast_off:
        assert property (!freewheel_override_n |=> (high_gate_out | low_gate_out) == '0)
        else $error("gate on under coast");
    a_both_off:
        assert property (1'b1 |=> ((high_gate_out | low_gate_out)
            & $past(phase_high_pin & phase_low_pin)) == '0) else $error("both pins drove");
    a_no_cross:
        assert property ((high_gate_out & low_gate_out) == '0) else $error("cross conduction");
    a_gate_cause:
        assert property ((high_gate_out | low_gate_out) != '0 |-> $past(freewheel_override_n))
        else $error("gate on after coast");
    a_pin_a_quiet:
        assert property (pin_a_analog_sel[1] [*2] |-> !pin_a) else $error("pin_a in analog mode");
    a_clear_fault:
        assert property (s_quiet [*3] |=> !pin_a) else $error("fault flag not cleared");
endmodule // tpgc_top_asserts

bind tpgc_top tpgc_top_asserts #(.NPHASE(NPHASE)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .phase_high_pin(phase_high_pin), .phase_low_pin(phase_low_pin),
    .freewheel_override_n(freewheel_override_n), .fault_clear_n(fault_clear_n),
    .stg_cmp(stg_cmp), .stb_cmp(stb_cmp), .overtemp_cmp(overtemp_cmp),
    .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
    .pin_a_analog_sel(pin_a_analog_sel), .pin_a(pin_a));

//--- dv/tpgc_host.sv
/* APB host model for the gate control bench.
   Assumes one clock; the bench watchdog ends a hung wait. */
`timescale 1ns/1ps
module tpgc_host
(
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // tpgc_host

//--- dv/three_phase_gate_control_logic_bench.sv
/* Self-checking bench for tpgc_top with an APB host model.
   Assumes PIN_A_DIV shortened to 8 and blank set to 4 cycles. */
`timescale 1ns/1ps
module three_phase_gate_control_logic_bench
    import tpgc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e, pin_a;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] phase_high_pin, phase_low_pin, stg_cmp, stb_cmp, hg, lg, ph, pl;
    logic freewheel_override_n, fault_clear_n, temp_warn_cmp, overtemp_cmp, prev;
    logic [2:0] high_gate_out, low_gate_out;
    logic [4:0] drain_source_threshold;
    logic [1:0] pin_a_analog_sel;
    logic [5:0] r;
    int n_fail = 0;
    int check_count = 0;
    int t;

    always #10 pclk = ~pclk;

    tpgc_host u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    tpgc_top #(.PIN_A_DIV(8), .NPHASE(3)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_high_pin(phase_high_pin),
        .phase_low_pin(phase_low_pin), .freewheel_override_n(freewheel_override_n),
        .fault_clear_n(fault_clear_n), .stg_cmp(stg_cmp), .stb_cmp(stb_cmp),
        .temp_warn_cmp(temp_warn_cmp), .overtemp_cmp(overtemp_cmp),
        .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
        .drain_source_threshold(drain_source_threshold),
        .pin_a_analog_sel(pin_a_analog_sel), .pin_a(pin_a));

    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x)
        begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q, e);
        chk(32'(e), 32'h0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        u_host.xfer(1'b0, a, 32'h0, q, e);
        chk(q, x);
        chk(32'(e), 32'(xe));
    endtask
    // reference: pin OR run bit, then one-hot decode unless coasting
    task gate_case(input logic [2:0] h, input logic [2:0] l, input logic [5:0] rr,
        input logic c);
        wr(TPGC_RUN_OFS, 32'(rr));
        phase_high_pin <= h;
        phase_low_pin <= l;
        freewheel_override_n <= c;
        hg = h | {rr[4], rr[2], rr[0]};
        lg = l | {rr[5], rr[3], rr[1]};
        repeat (2) @(posedge pclk);
        chk(32'(high_gate_out), c ? 32'(hg & ~lg) : 32'h0);
        chk(32'(low_gate_out), c ? 32'(lg & ~hg) : 32'h0);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #400000;
        n_fail++;
        final_report;
    end

    initial
    begin
        void'($urandom(31929));
        {phase_high_pin, phase_low_pin, stg_cmp, stb_cmp} = 12'h0;
        {freewheel_override_n, fault_clear_n, temp_warn_cmp, overtemp_cmp} = 4'hC;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(TPGC_RUN_OFS, 32'h0, 1'b0);
        rd(TPGC_CFG_OFS, 32'(TPGC_BLANK_RST) << TPGC_CFG_BLANK_LSB, 1'b0);
        rd(TPGC_STATUS_OFS, 32'h0, 1'b0);
        rd(TPGC_THRESH_OFS, 32'(TPGC_THRESH_RST), 1'b0);
        rd(8'h10, 32'h0, 1'b1);
        u_host.xfer(1'b1, 8'h10, 32'hFFFFFFFF, q, e);
        chk(32'(e), 32'h1);
        wr(TPGC_THRESH_OFS, 32'h13);
        rd(TPGC_THRESH_OFS, 32'h13, 1'b0);
        chk(32'(drain_source_threshold), 32'h13);
        for (int i = 0; i < 48; i++)
        begin
            ph = 3'($urandom);
            pl = 3'($urandom);
            r = 6'($urandom);
            // host drives pins or run bits, never both
            if (i % 2 == 1)
                {ph, pl} = 6'h0;
            else
                r = 6'h0;
            gate_case(ph, pl, r, ($urandom % 4) != 0);
        end
        gate_case(3'h0, 3'h0, 6'h0, 1'b1);
        // short pulse inside the blanking window must be ignored
        wr(TPGC_CFG_OFS, 32'h0400);
        wr(TPGC_RUN_OFS, 32'h01);
        stg_cmp <= 3'h1;
        // last high sample falls in the last cycle of the blank window
        repeat (6) @(posedge pclk);
        stg_cmp <= 3'h0;
        wr(TPGC_RUN_OFS, 32'h00);
        rd(TPGC_STATUS_OFS, 32'h0, 1'b0);
        wr(TPGC_RUN_OFS, 32'h01);
        stg_cmp <= 3'h1;
        repeat (12) @(posedge pclk);
        stg_cmp <= 3'h0;
        rd(TPGC_STATUS_OFS, 32'h101, 1'b0);
        chk(32'(pin_a), 32'h1);
        wr(TPGC_RUN_OFS, 32'h20);
        stb_cmp <= 3'h4;
        repeat (12) @(posedge pclk);
        stb_cmp <= 3'h0;
        rd(TPGC_STATUS_OFS, 32'h121, 1'b0);
        wr(TPGC_RUN_OFS, 32'h00);
        fault_clear_n <= 1'b0;
        repeat (3) @(posedge pclk);
        fault_clear_n <= 1'b1;
        rd(TPGC_STATUS_OFS, 32'h0, 1'b0);
        chk(32'(pin_a), 32'h0);
        temp_warn_cmp <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(TPGC_STATUS_OFS, 32'h40, 1'b0);
        overtemp_cmp <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(TPGC_STATUS_OFS, 32'h1C0, 1'b0);
        {temp_warn_cmp, overtemp_cmp} <= 2'h0;
        repeat (3) @(posedge pclk);
        rd(TPGC_STATUS_OFS, 32'h0, 1'b0);
        wr(TPGC_CFG_OFS, 32'h0401);
        repeat (4) @(posedge pclk);
        t = 0;
        prev = pin_a;
        repeat (16)
        begin
            @(posedge pclk);
            t += int'(pin_a !== prev);
            prev = pin_a;
        end
        chk(32'(t), 32'h4);
        for (int c = 2; c < 4; c++)
        begin
            wr(TPGC_CFG_OFS, 32'h0400 | 32'(c));
            repeat (3) @(posedge pclk);
            chk(32'(pin_a_analog_sel), 32'(c));
            chk(32'(pin_a), 32'h0);
        end
        final_report;
    end
endmodule // three_phase_gate_control_logic_bench
